//--- uar_rx.sv
// receive front end: pin synchroniser, start detection, bit recovery, queue
// assumes i_baud_divisor gives oversample tick period minus one in clocks
`timescale 1ns/100ps
module uar_rx
	import uar_pkg::*;
#(
	parameter int DIV_W = UAR_DIV_W
)
(
	input  wire logic              i_clock,
	input  wire logic              i_rst_n,
	input  wire logic              i_serial_rx_pin,
	input  wire logic              i_rx_enable,
	input  wire logic              i_double_speed_select,
	input  wire logic [DIV_W-1:0]  i_baud_divisor,
	input  wire logic [3:0]        i_char_len,
	input  wire logic              i_rx_data_read,
	output uar_char_t              o_rx_data_port,
	output logic                   o_rx_complete_flag,
	output logic                   o_framing_error_flag,
	output logic                   o_overrun
);
	// ****************************************************************
	// pin synchroniser and tick divider
	// ****************************************************************
	logic             sync1_r;
	logic             sync2_r;
	logic             line_prev_r;
	logic [DIV_W-1:0] div_r;
	logic             tick;

	// [R18] two stage sync
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			sync1_r <= UAR_SYNC_RST;
			sync2_r <= UAR_SYNC_RST;
		end
		else
		begin
			sync1_r <= i_serial_rx_pin;
			sync2_r <= sync1_r;
		end
	end

	// [R19] oversample tick divider
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n || div_r == '0)
			div_r <= i_baud_divisor;
		else
			div_r <= div_r - 1'b1;
	end
	assign tick = i_rst_n && (div_r == '0);

	// ****************************************************************
	// recovery state machine
	// ****************************************************************
	uar_state_t               state_r;
	logic [UAR_SAMP_W-1:0]    samp_r;
	logic [2:0]               votes_r;
	logic [3:0]               nbits_r;
	logic [UAR_DATA_W-1:0]    shift_r;
	logic [3:0]               len_eff;
	logic [4:0]               spb;
	logic [4:0]               vfirst;
	logic                     vote_done;
	logic                     bit_end;
	logic                     push;
	uar_char_t                push_char;

	function automatic logic majority(input logic [2:0] v);
		return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction : majority

	// [R03] rate by mode
	assign spb    = i_double_speed_select ? UAR_SPB_DBL : UAR_SPB_NORM;
	assign vfirst = i_double_speed_select ? UAR_VOTE_DBL : UAR_VOTE_NORM;
	// [R13] length clamped
	assign len_eff = (i_char_len < UAR_LEN_MIN) ? UAR_LEN_MIN :
		(i_char_len > UAR_LEN_MAX) ? UAR_LEN_MAX : i_char_len;
	assign vote_done = tick && (samp_r == vfirst + 5'h2);
	assign bit_end   = tick && (samp_r == spb);

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			line_prev_r <= 1'b1;
		else if (tick)
			line_prev_r <= sync2_r;
	end

	// [R05] [R09] three centre samples
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			votes_r <= 3'h0;
		else if (tick && samp_r >= vfirst && samp_r <= vfirst + 5'h2)
			votes_r <= {votes_r[1:0], sync2_r};
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n || !i_rx_enable)
		begin
			state_r <= UAR_IDLE;
			samp_r  <= 5'h0;
			nbits_r <= 4'h0;
			shift_r <= '0;
		end
		else if (tick)
		begin
			unique case (state_r)
				UAR_IDLE:
				begin
					// [R04] falling edge, sample 1
					if (line_prev_r && !sync2_r)
					begin
						state_r <= UAR_START;
						samp_r  <= UAR_SAMP_FIRST;
					end
				end
				UAR_START:
				begin
					samp_r <= samp_r + 5'h1;
					// [R06] noise rejection
					if (samp_r == vfirst + 5'h2)
					begin
						if (majority({votes_r[1:0], sync2_r}))
							state_r <= UAR_IDLE;
					end
					// [R07] realign to start
					if (samp_r == spb)
					begin
						state_r <= UAR_BITS;
						samp_r  <= UAR_SAMP_FIRST;
						nbits_r <= 4'h0;
						shift_r <= '0;
					end
				end
				UAR_BITS:
				begin
					// [R08] per bit states
					samp_r <= (samp_r == spb) ? UAR_SAMP_FIRST : samp_r + 5'h1;
					if (samp_r == vfirst + 5'h2)
					begin
						shift_r[nbits_r] <= majority({votes_r[1:0], sync2_r});
						nbits_r          <= nbits_r + 4'h1;
					end
					// [R10] stop after last bit
					if (samp_r == spb && nbits_r == len_eff)
						state_r <= UAR_STOP;
				end
				UAR_STOP:
				begin
					samp_r <= samp_r + 5'h1;
					// [R12] early next start
					if (samp_r == vfirst + 5'h2)
						state_r <= UAR_IDLE;
				end
			endcase
		end
	end

	// [R11] stop bit vote
	assign push = i_rx_enable && state_r == UAR_STOP && vote_done;
	assign push_char = '{data: shift_r, frame_err: !majority({votes_r[1:0], sync2_r})};

	// ****************************************************************
	// receive queue and outputs
	// ****************************************************************
	uar_char_t head;
	logic      q_valid;
	logic      q_full;
	logic      pop;

	assign pop = i_rx_data_read && o_rx_complete_flag;

	uar_queue u_queue (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_flush (!i_rx_enable),
		.i_push  (push),
		.i_char  (push_char),
		.i_pop   (pop),
		.o_head  (head),
		.o_valid (q_valid),
		.o_full  (q_full)
	);

	// [R16] flag tracks queue
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			o_rx_data_port       <= '0;
			o_rx_complete_flag   <= 1'b0;
			o_framing_error_flag <= 1'b0;
			o_overrun            <= 1'b0;
		end
		else
		begin
			// [R17] error with character
			o_rx_data_port       <= head;
			o_rx_complete_flag   <= q_valid && !pop;
			o_framing_error_flag <= q_valid && head.frame_err;
			if (!i_rx_enable)
				o_overrun <= 1'b0;
			else if (push && q_full && !pop)
				o_overrun <= 1'b1;
			else if (push)
				o_overrun <= 1'b0;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	// the flag lags the queue by one register, hence the extra cycle below
	// sequences name the steps of a frame and the clocks between ticks so the properties stay short

	// start vote seen high on its last sample: a noise spike
	sequence start_noise_s;
		state_r == UAR_START && tick && samp_r == vfirst + 5'h2 &&
			majority({votes_r[1:0], sync2_r});
	endsequence : start_noise_s

	// last vote of the first stop bit
	sequence stop_vote_s;
		state_r == UAR_STOP && vote_done && i_rx_enable;
	endsequence : stop_vote_s

	// last state of a bit while enabled
	sequence bit_last_s;
		state_r == UAR_BITS && bit_end && i_rx_enable;
	endsequence : bit_last_s

	// a clock between oversample ticks
	sequence no_tick_s;
		!tick && i_rx_enable;
	endsequence : no_tick_s

	// [R01] disable empties
	flush_empty_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R01]
		!i_rx_enable |=> ##1 !o_rx_complete_flag)
		else $error("buffer not flushed");

	// [R04] edge starts sequence
	edge_start_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R04]
		(state_r == UAR_IDLE && tick && line_prev_r && !sync2_r && i_rx_enable)
		|=> state_r == UAR_START && samp_r == 5'h01)
		else $error("start not begun");

	// [R16] empty queue clears flag
	flag_empty_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R16]
		!q_valid |=> !o_rx_complete_flag)
		else $error("flag high while empty");

	// [R16] unread data raises flag
	flag_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R16]
		(q_valid && !pop && i_rx_enable) |=> o_rx_complete_flag)
		else $error("flag low with data");

	// [R06] noise spike dropped
	noise_reject_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R06]
		start_noise_s |=> state_r == UAR_IDLE)
		else $error("noise start kept");

	// [R12] idle right after stop vote
	early_idle_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R12]
		stop_vote_s |-> push ##1 state_r == UAR_IDLE)
		else $error("stop vote did not free receiver");

	// [R08] bit states wrap
	bit_wrap_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R08]
		bit_last_s |=> samp_r == UAR_SAMP_FIRST)
		else $error("bit state did not wrap");

	// [R10] stop after last bit
	stop_enter_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R10]
		(bit_last_s ##0 nbits_r == len_eff) |=> state_r == UAR_STOP)
		else $error("stop bit not entered");

	// [R19] counter moves on ticks only
	samp_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R19]
		no_tick_s |=> $stable(samp_r))
		else $error("sample counter moved without tick");

	// [R15] push into full queue flagged
	overrun_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R15]
		(push && q_full && !pop) |=> o_overrun)
		else $error("overrun not flagged");

	// [R13] length kept in range
	len_range_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R13]
		len_eff >= UAR_LEN_MIN && len_eff <= UAR_LEN_MAX)
		else $error("character length out of range");

endmodule : uar_rx

//--- uar_pkg.sv
// package for the asynchronous receive front end: constants and carriers
// assumes a single 200 MHz clock and an external baud divisor value
//
// Summary of operation
// [R01] disabling receiver flushes whole receive buffer
// [R02] host drains buffer by reading until empty
// [R03] oversample x16 normal, x8 double speed
// [R04] falling edge starts detection, first sample 1
// [R05] validate start on samples 8-10 or 4-6
// [R06] two high votes reject start as noise
// [R07] realign bit timing on every start bit
// [R08] sixteen or eight states per bit
// [R09] centre three samples majority decide bit
// [R10] receive through first stop bit only
// [R11] zero stop bit sets framing error
// [R12] next start accepted right after stop votes
// [R13] frames carry five to ten data bits
// [R14] host keeps baud error within limits
// [R15] two-entry queue, read returns oldest
// [R16] complete flag high while unread data remain; the code drops it for one cycle after each read
// [R17] framing error stored with its character
// [R18] receive pin synchronised by two flops
// [R19] sample counter steps on oversample ticks
package uar_pkg;

	// ****************************************************************
	// constants
	// ****************************************************************
	localparam int          UAR_DATA_W      = 10;
	localparam int          UAR_DIV_W       = 12;
	localparam int          UAR_SAMP_W      = 5;
	localparam logic [4:0]  UAR_SPB_NORM    = 5'h10;
	localparam logic [4:0]  UAR_SPB_DBL     = 5'h08;
	localparam logic [4:0]  UAR_VOTE_NORM   = 5'h08;
	localparam logic [4:0]  UAR_VOTE_DBL    = 5'h04;
	localparam logic [4:0]  UAR_SAMP_FIRST  = 5'h01;
	localparam logic [3:0]  UAR_LEN_MIN     = 4'h5;
	localparam logic [3:0]  UAR_LEN_MAX     = 4'hA;
	localparam int          UAR_QDEPTH      = 2;
	localparam logic        UAR_SYNC_RST    = 1'b1;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic [UAR_DATA_W-1:0] data;
		logic                  frame_err;
	} uar_char_t;

	typedef enum logic [1:0] {
		UAR_IDLE,
		UAR_START,
		UAR_BITS,
		UAR_STOP
	} uar_state_t;

endpackage : uar_pkg

//--- uar_queue.sv
// two-entry receive queue holding characters with their error flag
// assumes push and pop come from logic on the same clock
`timescale 1ns/100ps
module uar_queue
	import uar_pkg::*;
(
	input  wire logic      i_clock,
	input  wire logic      i_rst_n,
	input  wire logic      i_flush,
	input  wire logic      i_push,
	input  wire uar_char_t i_char,
	input  wire logic      i_pop,
	output uar_char_t      o_head,
	output logic           o_valid,
	output logic           o_full
);
	uar_char_t    mem_r [UAR_QDEPTH];
	logic         rd_r;
	logic [1:0]   cnt_r;
	logic         do_pop;
	logic         do_push;

	assign do_pop  = i_pop && (cnt_r != 2'h0);
	assign do_push = i_push && (cnt_r != 2'h2 || do_pop);

	// [R15] oldest first
	always_ff @(posedge i_clock)
	begin
		if (do_push)
			mem_r[rd_r ^ cnt_r[0]] <= i_char;
	end

	// [R01] flush empties
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n || i_flush)
		begin
			cnt_r <= 2'h0;
			rd_r  <= 1'b0;
		end
		else
		begin
			cnt_r <= 2'(cnt_r + {1'b0, do_push} - {1'b0, do_pop});
			if (do_pop)
				rd_r <= ~rd_r;
		end
	end

	assign o_head  = mem_r[rd_r];
	assign o_valid = cnt_r != 2'h0;
	assign o_full  = cnt_r == 2'h2;

endmodule : uar_queue

//--- uar_line_model.sv
// serial transmitter model that drives the receive line
// assumes the bench clock; the line idles high between frames
`timescale 1ns/100ps
module uar_line_model
	import uar_pkg::*;
(
	input  wire logic i_clock,
	output logic      o_line
);
	initial o_line = 1'b1;
	// ****************************************************************
	// frames
	// ****************************************************************
	// exact bit period, lsb first
	task send(input logic [9:0] d, input int n, input logic stp, input int per, input int sl);
		o_line <= 1'b0;
		repeat (per) @(posedge i_clock);
		for (int k = 0; k < n; k++)
		begin
			o_line <= d[k];
			repeat (per) @(posedge i_clock);
		end
		o_line <= stp;
		repeat (sl) @(posedge i_clock);
		// a high stop already idles the line, so a next start may follow at once
		if (!stp)
		begin
			o_line <= 1'b1;
			@(posedge i_clock);
		end
	endtask : send
	// short low pulse, too brief to pass the start vote
	task glitch(input int n);
		o_line <= 1'b0;
		repeat (n) @(posedge i_clock);
		o_line <= 1'b1;
	endtask : glitch
endmodule : uar_line_model

//--- tb.sv
// self-checking bench for the receive front end
// assumes the line model above stands in for the remote transmitter
`timescale 1ns/100ps
module tb;
	import uar_pkg::*;
	logic        i_clock = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        en = 1'b1;
	logic        ds = 1'b0;
	logic        rd = 1'b0;
	logic [11:0] div = 12'h003;
	logic [3:0]  len = 4'h8;
	logic        line;
	uar_char_t   dp;
	logic        fl;
	logic        fe;
	logic        ov;
	logic [9:0]  d [3];
	int          error_cnt = 0;
	int          n_checks = 0;
	int          seed = 32'h33d3c1f7;
	int          per;
	always #2.5 i_clock = ~i_clock;
	uar_line_model tx (.i_clock(i_clock), .o_line(line));
	uar_rx uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_serial_rx_pin(line),
		.i_rx_enable(en), .i_double_speed_select(ds), .i_baud_divisor(div),
		.i_char_len(len), .i_rx_data_read(rd), .o_rx_data_port(dp),
		.o_rx_complete_flag(fl), .o_framing_error_flag(fe), .o_overrun(ov));
	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [10:0] expect_char(logic [9:0] v, int n, logic e);
		return {v & 10'((1 << n) - 1), e};
	endfunction : expect_char
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	task chk(input logic [10:0] got, input logic [10:0] exp, input string m);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	task wait_fl;
		int t;
		for (t = 0; t < 4000 && fl !== 1'b1; t++)
			@(posedge i_clock);
		if (t == 4000)
		begin
			error_cnt++;
			wrap_up();
		end
	endtask : wait_fl
	// check head then pop it; new head shows two cycles later
	task rd_chk(input logic [9:0] v, input int n, input logic e);
		wait_fl();
		chk(dp, expect_char(v, n, e), "head");
		chk(fe, e, "frame err");
		rd <= 1'b1;
		@(posedge i_clock);
		rd <= 1'b0;
		repeat (3) @(posedge i_clock);
	endtask : rd_chk
	// ****************************************************************
	// sequence
	// ****************************************************************
	initial
	begin
		repeat (5) @(posedge i_clock);
		i_rst_n <= 1'b1;
		@(posedge i_clock);
		chk(fl, 0, "flag reset");
		for (int i = 0; i < 12; i++)
		begin
			ds <= (i >= 6);
			len <= 4'(5 + i % 6);
			d[0] = 10'($random(seed));
			per = 4 * ((i >= 6) ? 8 : 16);
			@(posedge i_clock);
			tx.send(d[0], 5 + i % 6, 1'b1, per, per);
			rd_chk(d[0], 5 + i % 6, 1'b0);
		end
		$display("test speeds done");
		ds <= 1'b0;
		len <= 4'h8;
		per = 64;
		tx.send(10'h0A5, 8, 1'b0, per, per);
		rd_chk(10'h0A5, 8, 1'b1);
		tx.glitch(16);
		repeat (2 * per) @(posedge i_clock);
		chk(fl, 0, "noise");
		$display("test errors done");
		// early starts after the stop vote fill the queue and overrun it
		for (int i = 0; i < 3; i++)
		begin
			d[i] = 10'($random(seed));
			tx.send(d[i], 8, 1'b1, per, 44);
		end
		repeat (per) @(posedge i_clock);
		chk(ov, 1, "overrun");
		rd_chk(d[0], 8, 1'b0);
		rd_chk(d[1], 8, 1'b0);
		chk(fl, 0, "drained");
		tx.send(10'h3C, 8, 1'b1, per, per);
		wait_fl();
		en <= 1'b0;
		repeat (3) @(posedge i_clock);
		chk(fl, 0, "flush");
		$display("test queue done");
		wrap_up();
	end
endmodule : tb
